//--- hdl/irq_enable_pkg.sv
// package: register map, field layout and bus types of the enable bank
`default_nettype none
package irq_enable_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_GROUPS = 6;
  localparam int GROUP_W = 16;
  localparam int PRIO_W = 3;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam logic [2:0] PRIO_TOP = 3'h7;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ENABLE_BASE = 8'h00;
  localparam logic [7:0] PENDING_BASE = 8'h20;
  localparam logic [7:0] BANK_SPAN = 8'h18;
  localparam logic [7:0] IRQ_STATUS = 8'h40;
  localparam logic [7:0] IRQ_MASK = 8'h44;

  // ----------------------------------------------------------------
  // reset values, implemented bits, bus answers
  // ----------------------------------------------------------------
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [5:0] STATUS_RESET = 6'h00;
  localparam logic [5:0] MASK_RESET = 6'h00;
  localparam logic [NUM_GROUPS-1:0][15:0] IMPL_MASK = {
    16'h0790, 16'h33ce, 16'he10e, 16'h6066, 16'h7ff3, 16'hffdf};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // field positions of the gated sources
  // ----------------------------------------------------------------
  localparam int EXT_PIN1_IRQ_EN = 4;
  localparam int CHANGE_NOTIFY_IRQ_EN = 3;
  localparam int COMPARATOR_IRQ_EN = 2;
  localparam int I2C_CH1_MASTER_IRQ_EN = 1;
  localparam int I2C_CH1_SLAVE_IRQ_EN = 0;
  localparam int DMA_CH4_IRQ_EN = 14;
  localparam int PARALLEL_PORT_IRQ_EN = 13;
  localparam int COMPARE_CH8_IRQ_EN = 12;
  localparam int CAPTURE_CH3_IRQ_EN = 5;
  localparam int DMA_CH3_IRQ_EN = 4;
  localparam int SPI_CH2_EVENT_IRQ_EN = 1;
  localparam int SPI_CH2_FAULT_IRQ_EN = 0;
  localparam int CALENDAR_IRQ_EN = 14;
  localparam int DMA_CH5_IRQ_EN = 13;
  localparam int EXT_PIN4_IRQ_EN = 6;
  localparam int EXT_PIN3_IRQ_EN = 5;
  localparam int I2C_CH2_MASTER_IRQ_EN = 2;
  localparam int I2C_CH2_SLAVE_IRQ_EN = 1;
  localparam int DAC_B_IRQ_EN = 15;
  localparam int DAC_A_IRQ_EN = 14;
  localparam int CHARGE_TIME_IRQ_EN = 13;
  localparam int VOLTAGE_DETECT_IRQ_EN = 8;
  localparam int CRC_GEN_IRQ_EN = 3;
  localparam int UART_CH2_ERROR_IRQ_EN = 2;
  localparam int UART_CH1_ERROR_IRQ_EN = 1;
  localparam int CAPTURE_CH9_IRQ_EN = 13;
  localparam int COMPARE_CH9_IRQ_EN = 12;
  localparam int UART_CH4_TX_IRQ_EN = 9;
  localparam int UART_CH4_RX_IRQ_EN = 8;
  localparam int UART_CH4_ERROR_IRQ_EN = 7;
  localparam int USB_CTRL_IRQ_EN = 6;
  localparam int UART_CH3_TX_IRQ_EN = 3;
  localparam int UART_CH3_RX_IRQ_EN = 2;
  localparam int UART_CH3_ERROR_IRQ_EN = 1;
  localparam int OSC_SELFTUNE_IRQ_EN = 10;
  localparam int SIGMA_DELTA_IRQ_EN = 9;
  localparam int OPAMP_B_IRQ_EN = 8;
  localparam int OPAMP_A_IRQ_EN = 7;
  localparam int LCD_CTRL_IRQ_EN = 4;

  // one accepted register write, handed from the bus port to the bank
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } bus_wr_t;

  // word address falls inside a six-register bank starting at base
  function automatic logic in_bank(input logic [7:0] a,
                                   input logic [7:0] base);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return (w >= base) && (w < base + BANK_SPAN);
  endfunction

  // register index inside a bank
  function automatic logic [2:0] bank_index(input logic [7:0] a,
                                            input logic [7:0] base);
    logic [7:0] d;
    d = {a[7:2], 2'b00} - base;
    return d[4:2];
  endfunction

  // any register at all answers at this address
  function automatic logic reg_mapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return in_bank(a, ENABLE_BASE) || in_bank(a, PENDING_BASE) ||
      (w == IRQ_STATUS) || (w == IRQ_MASK);
  endfunction

endpackage
`default_nettype wire

//--- hdl/axil_reg_port.sv
// module: axi4-lite slave front end feeding the enable bank registers
`default_nettype none
module axil_reg_port (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // asynchronous reset, active low
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [7:0] awaddr, // write byte address
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response code
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [7:0] araddr, // read byte address
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response code
  output var irq_enable_pkg::bus_wr_t wr, // one-cycle register write
  output logic [7:0] rd_addr, // address for the read mux
  input wire logic [31:0] rd_data // word selected by the read mux
);

  typedef enum logic [1:0] {WR_COLLECT = 2'b01, WR_RESP = 2'b10} wr_state_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} rd_state_t;

  wr_state_t wr_state;
  rd_state_t rd_state;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // the mux looks at the live address; it is only sampled at the handshake
  assign rd_addr = araddr;

  // --------------------------------------------------------------
  // write channel
  // --------------------------------------------------------------
  // address and data are caught in either order, then one write pulse
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_state <= WR_COLLECT;
      awready <= 1'b0;
      wready <= 1'b0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= irq_enable_pkg::RESP_OKAY;
      wr <= '0;
    end
    else
    begin
      wr.en <= 1'b0;
      unique case (wr_state)
        WR_COLLECT:
        begin
          if (awvalid && awready)
          begin
            aw_addr <= awaddr;
            aw_got <= 1'b1;
            awready <= 1'b0;
          end
          else if (!aw_got)
            awready <= 1'b1;
          if (wvalid && wready)
          begin
            w_data <= wdata;
            w_strb <= wstrb;
            w_got <= 1'b1;
            wready <= 1'b0;
          end
          else if (!w_got)
            wready <= 1'b1;
          if (aw_got && w_got)
          begin
            wr <= '{en: 1'b1, addr: aw_addr, data: w_data, strb: w_strb};
            bresp <= irq_enable_pkg::reg_mapped(aw_addr) ?
              irq_enable_pkg::RESP_OKAY : irq_enable_pkg::RESP_SLVERR;
            bvalid <= 1'b1;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            wr_state <= WR_RESP;
          end
        end
        WR_RESP:
        begin
          if (bready)
          begin
            bvalid <= 1'b0;
            wr_state <= WR_COLLECT;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------
  // data is captured at the address handshake, so it never changes
  // while rvalid waits for rready
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_state <= RD_IDLE;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= irq_enable_pkg::RESP_OKAY;
    end
    else
    begin
      unique case (rd_state)
        RD_IDLE:
        begin
          if (arvalid && arready)
          begin
            rdata <= rd_data;
            rresp <= irq_enable_pkg::reg_mapped(araddr) ?
              irq_enable_pkg::RESP_OKAY : irq_enable_pkg::RESP_SLVERR;
            rvalid <= 1'b1;
            arready <= 1'b0;
            rd_state <= RD_RESP;
          end
          else
            arready <= 1'b1;
        end
        RD_RESP:
        begin
          if (rready)
          begin
            rvalid <= 1'b0;
            rd_state <= RD_IDLE;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- hdl/interrupt_enable_bank.sv
// module: interrupt enable bank with gating, priority qualify and irq
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`default_nettype none

// Behaviour
// - enable 1 passes a source request; enable 0 blocks it.
// - unimplemented enable bits read zero and ignore writes.
// - reset clears every enable bit, blocking all sources.
// - group 1 low bits gate ext pin 1, change notify, comparators, i2c 1.
// - group 2 gates dma 4, parallel port, compare, capture, dma 3, spi 2.
// - group 3 gates calendar, dma 5, ext pins 4 and 3, i2c 2.
// - group 4 gates both dacs, charge time, voltage detect, crc, uarts.
// - group 5 gates capture 9, compare 9, uart 4, usb, uart 3.
// - group 6 gates self-tune, sigma-delta, both op amps, lcd.
// - each source flag is qualified by its enable bit.
// - priority 111 highest, 001 lowest, 000 disables the source.
module interrupt_enable_bank (
  input wire logic sys_clk, // system clock, 100 MHz
  input wire logic rstn, // asynchronous reset, active low
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [7:0] awaddr, // write byte address
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response code
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [7:0] araddr, // read byte address
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response code
  input wire logic [5:0][15:0] src_flag, // per-source flag status
  input wire logic [5:0][15:0][2:0] src_prio, // per-source priority
  output logic [5:0][15:0] irq_req, // qualified requests to arbitration
  output logic [2:0] best_prio, // highest priority among requests
  output logic irq // level interrupt, unmasked group event
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [5:0][15:0] enable;
  logic [5:0][15:0] next_req;
  logic [2:0] next_best;
  logic [5:0] status;
  logic [5:0] mask;
  logic [5:0] next_status;
  logic [5:0] next_mask;
  logic [5:0] grp_event;
  logic [5:0] status_clr;
  logic status_hit;
  logic mask_hit;
  irq_enable_pkg::bus_wr_t wr;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;

  // byte strobes to a 16-bit lane mask; registers sit in the low half
  function automatic logic [15:0] lane_mask(input logic [3:0] strb);
    return {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  axil_reg_port u_port (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // ----------------------------------------------------------------
  // enable registers
  // ----------------------------------------------------------------
  // one register per group; the implemented mask keeps reserved bits
  // at zero forever, so neither reads nor the gate ever see them
  for (genvar g = 0; g < irq_enable_pkg::NUM_GROUPS; g++)
  begin : g_enable
    logic [15:0] wmask;
    logic sel;
    assign wmask = lane_mask(wr.strb) & irq_enable_pkg::IMPL_MASK[g];
    assign sel = wr.en &&
      irq_enable_pkg::in_bank(wr.addr, irq_enable_pkg::ENABLE_BASE) &&
      (irq_enable_pkg::bank_index(wr.addr, irq_enable_pkg::ENABLE_BASE)
       == 3'(g));
    // software write merges only the selected, implemented lanes
    always_ff @(posedge sys_clk or negedge rstn)
    begin
      if (!rstn)
        enable[g] <= irq_enable_pkg::ENABLE_RESET;
      else if (sel)
        enable[g] <= (enable[g] & ~wmask) | (wr.data[15:0] & wmask);
    end
  end

  // ----------------------------------------------------------------
  // request gate
  // ----------------------------------------------------------------
  // a source reaches arbitration only with flag, enable and a live
  // priority together; the bit positions of every group come from the
  // enable layout, so the same gate serves all six registers
  always_comb
  begin
    next_req = '0;
    for (int g = 0; g < irq_enable_pkg::NUM_GROUPS; g++)
    begin
      for (int b = 0; b < irq_enable_pkg::GROUP_W; b++)
      begin
        next_req[g][b] = src_flag[g][b] & enable[g][b] &
          (src_prio[g][b] != irq_enable_pkg::PRIO_OFF);
      end
    end
  end

  // highest live priority, registered with the requests so arbitration sees both in the same cycle
  always_comb
  begin
    next_best = irq_enable_pkg::PRIO_OFF;
    for (int g = 0; g < irq_enable_pkg::NUM_GROUPS; g++)
    begin
      for (int b = 0; b < irq_enable_pkg::GROUP_W; b++)
      begin
        if (next_req[g][b] && (src_prio[g][b] > next_best))
          next_best = src_prio[g][b];
      end
    end
  end

  // requests are re-evaluated every cycle and registered, one cycle late
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_req <= '0;
      best_prio <= irq_enable_pkg::PRIO_OFF;
    end
    else
    begin
      irq_req <= next_req;
      best_prio <= next_best;
    end
  end

  // ----------------------------------------------------------------
  // group events, sticky status, mask and interrupt line
  // ----------------------------------------------------------------
  // an event is a group going from no request to at least one
  for (genvar g = 0; g < irq_enable_pkg::NUM_GROUPS; g++)
  begin : g_event
    assign grp_event[g] = (|next_req[g]) & ~(|irq_req[g]);
  end

  assign status_hit = wr.en && wr.strb[0] &&
    ({wr.addr[7:2], 2'b00} == irq_enable_pkg::IRQ_STATUS);
  assign mask_hit = wr.en && wr.strb[0] &&
    ({wr.addr[7:2], 2'b00} == irq_enable_pkg::IRQ_MASK);
  assign status_clr = status_hit ? wr.data[5:0] : 6'h00;

  // write one to clear; an event in the same cycle wins over the clear
  always_comb
  begin
    next_status = (status & ~status_clr) | grp_event;
    next_mask = mask_hit ? wr.data[5:0] : mask;
  end

  // irq follows the next values so it rises with the status bit itself
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status <= irq_enable_pkg::STATUS_RESET;
      mask <= irq_enable_pkg::MASK_RESET;
      irq <= 1'b0;
    end
    else
    begin
      status <= next_status;
      mask <= next_mask;
      irq <= |(next_status & next_mask);
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // the pending view shows flags already qualified by enable, without
  // the priority, so software can see a source parked at priority zero
  always_comb
  begin
    logic [2:0] idx;
    idx = 3'h0;
    rd_data = 32'h0000_0000;
    if (irq_enable_pkg::in_bank(rd_addr, irq_enable_pkg::ENABLE_BASE))
    begin
      idx = irq_enable_pkg::bank_index(rd_addr, irq_enable_pkg::ENABLE_BASE);
      rd_data = {16'h0000, enable[idx]};
    end
    else if (irq_enable_pkg::in_bank(rd_addr, irq_enable_pkg::PENDING_BASE))
    begin
      idx = irq_enable_pkg::bank_index(rd_addr, irq_enable_pkg::PENDING_BASE);
      rd_data = {16'h0000, src_flag[idx] & enable[idx]};
    end
    else if ({rd_addr[7:2], 2'b00} == irq_enable_pkg::IRQ_STATUS)
      rd_data = {26'h000_0000, status};
    else if ({rd_addr[7:2], 2'b00} == irq_enable_pkg::IRQ_MASK)
      rd_data = {26'h000_0000, mask};
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // one source, one cycle: request equals the registered cause
  property p_gate(int g, int b);
    @(posedge sys_clk) disable iff (!rstn)
    1'b1 |=> (irq_req[g][b] == ($past(src_flag[g][b]) &&
      $past(enable[g][b]) &&
      ($past(src_prio[g][b]) != irq_enable_pkg::PRIO_OFF)));
  endproperty

  a_blocked_source: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ##1 ((irq_req & ~$past(enable)) == '0))
    else $error("request passed a cleared enable bit");

  a_reserved_zero: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (enable & ~irq_enable_pkg::IMPL_MASK) == '0)
    else $error("unimplemented enable bit is set");

  a_reset_clear: assert property (
    @(posedge sys_clk)
    !rstn |-> (enable == '0) && (irq_req == '0) && !irq)
    else $error("state not cleared under reset");

  a_grp1_bits: assert property (
    p_gate(0, irq_enable_pkg::EXT_PIN1_IRQ_EN))
    else $error("ext pin 1 gate wrong");

  a_grp2_bits: assert property (
    p_gate(1, irq_enable_pkg::DMA_CH4_IRQ_EN))
    else $error("dma 4 gate wrong");

  a_grp3_bits: assert property (
    p_gate(2, irq_enable_pkg::EXT_PIN3_IRQ_EN))
    else $error("ext pin 3 gate wrong");

  a_grp4_bits: assert property (
    p_gate(3, irq_enable_pkg::DAC_B_IRQ_EN))
    else $error("dac b gate wrong");

  a_grp5_bits: assert property (
    p_gate(4, irq_enable_pkg::USB_CTRL_IRQ_EN))
    else $error("usb gate wrong");

  a_grp6_bits: assert property (
    p_gate(5, irq_enable_pkg::LCD_CTRL_IRQ_EN))
    else $error("lcd gate wrong");

  a_flag_qualify: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    ##1 ((irq_req & ~$past(src_flag)) == '0))
    else $error("request without its flag");

  a_prio_zero: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (src_prio[0][irq_enable_pkg::COMPARATOR_IRQ_EN] ==
      irq_enable_pkg::PRIO_OFF) |=>
    !irq_req[0][irq_enable_pkg::COMPARATOR_IRQ_EN])
    else $error("priority zero source still requests");

  a_best_level: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (irq_req == '0) == (best_prio == irq_enable_pkg::PRIO_OFF))
    else $error("best priority disagrees with requests");

  a_enable_write: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (wr.en && (wr.addr == irq_enable_pkg::ENABLE_BASE) &&
      (wr.strb == 4'hf)) |=>
    (enable[0] == ($past(wr.data[15:0]) & irq_enable_pkg::IMPL_MASK[0])))
    else $error("enable write not stored");

  a_irq_level: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    irq == |(status & mask))
    else $error("irq disagrees with status and mask");

  c_enable_write: cover property (
    @(posedge sys_clk) disable iff (!rstn)
    wr.en && irq_enable_pkg::in_bank(wr.addr, irq_enable_pkg::ENABLE_BASE));

  c_irq_rise: cover property (
    @(posedge sys_clk) disable iff (!rstn)
    $rose(irq));

  c_top_prio: cover property (
    @(posedge sys_clk) disable iff (!rstn)
    best_prio == irq_enable_pkg::PRIO_TOP);

endmodule
`default_nettype wire

//--- test/irq_source_model.sv
// partner model: peripheral sources raising flags with priorities
`default_nettype none
module irq_source_model (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // asynchronous reset, active low
  input wire logic [5:0][15:0] flag_cmd, // flags the peripherals raise
  input wire logic [2:0] prio_cmd, // priority of every source
  output logic [5:0][15:0] src_flag, // flag status toward the bank
  output logic [5:0][15:0][2:0] src_prio // priority toward the bank
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // sources
  // ----------------------------------------------------------------
  // pin sources count as already routed to a remap pin
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      src_flag <= '0;
      src_prio <= '0;
    end
    else
    begin
      src_flag <= flag_cmd;
      src_prio <= {96{prio_cmd}};
    end
  end
endmodule
`default_nettype wire

//--- test/tb_interrupt_enable_bank.sv
// testbench: register access, gating, priority and interrupt of the bank
`default_nettype none
module tb_interrupt_enable_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, irq, pa, pw;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, a;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd_val;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, resp;
  logic [5:0][15:0] src_flag, irq_req, flag_cmd = '0;
  logic [5:0][15:0][2:0] src_prio;
  logic [2:0] prio_cmd = 3'h1, best_prio;
  int bad_count = 0;
  int n_checks = 0;

  // 100 MHz system clock
  always #5 sys_clk = ~sys_clk;

  interrupt_enable_bank i_dut (.sys_clk(sys_clk), .rstn(rstn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .src_flag(src_flag), .src_prio(src_prio), .irq_req(irq_req),
    .best_prio(best_prio), .irq(irq));

  irq_source_model i_src (.sys_clk(sys_clk), .rstn(rstn),
    .flag_cmd(flag_cmd), .prio_cmd(prio_cmd), .src_flag(src_flag),
    .src_prio(src_prio));

  // ----------------------------------------------------------------
  // bus tasks and checks
  // ----------------------------------------------------------------
  // bready and rready stay high, so a task may follow at the same edge
  task automatic chk(input string nm, input logic [31:0] e, got);
    n_checks++;
    if (got !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, got);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (pa || pw)
    begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      pa = pa && !awready;
      pw = pw && !wready;
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask

  task automatic rd(input logic [7:0] ad);
    araddr <= ad;
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rd_val = rdata;
    resp = rresp;
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int g = 0; g < 6; g++)
    begin
      rd(irq_enable_pkg::ENABLE_BASE + 8'(4 * g));
      chk("enable reset", 32'h0000_0000, rd_val);
    end
    wr(irq_enable_pkg::IRQ_MASK, 32'h0000_003f);
    flag_cmd <= '1;
    repeat (3) @(posedge sys_clk);
    chk("blocked", 32'h0000_0000, 32'(|irq_req));
    // open each group fully; only implemented bits may stick
    for (int g = 0; g < 6; g++)
    begin
      a = irq_enable_pkg::ENABLE_BASE + 8'(4 * g);
      wr(a, 32'hffff_ffff);
      rd(a);
      chk("enable", 32'(irq_enable_pkg::IMPL_MASK[g]), rd_val);
      rd(irq_enable_pkg::PENDING_BASE + 8'(4 * g));
      chk("pending", 32'(irq_enable_pkg::IMPL_MASK[g]), rd_val);
      chk("req", 32'(irq_enable_pkg::IMPL_MASK[g]), 32'(irq_req[g]));
    end
    chk("irq", 32'h0000_0001, 32'(irq));
    chk("best", 32'h0000_0001, 32'(best_prio));
    prio_cmd <= 3'h7;
    repeat (3) @(posedge sys_clk);
    chk("best", 32'h0000_0007, 32'(best_prio));
    // priority zero blocks even with flag and enable set
    prio_cmd <= 3'h0;
    repeat (3) @(posedge sys_clk);
    chk("prio off", 32'h0000_0000, 32'(|irq_req));
    wr(irq_enable_pkg::IRQ_STATUS, 32'h0000_003f);
    rd(irq_enable_pkg::IRQ_STATUS);
    chk("status", 32'h0000_0000, rd_val);
    chk("irq", 32'h0000_0000, 32'(irq));
    // a new event while masked sets status but not irq
    wr(irq_enable_pkg::IRQ_MASK, 32'h0000_0000);
    prio_cmd <= 3'h1;
    repeat (3) @(posedge sys_clk);
    rd(irq_enable_pkg::IRQ_STATUS);
    chk("status", 32'h0000_003f, rd_val);
    chk("irq", 32'h0000_0000, 32'(irq));
    wr(irq_enable_pkg::IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h0000_0001, 32'(irq));
    wr(irq_enable_pkg::ENABLE_BASE, 32'h0000_0000);
    repeat (3) @(posedge sys_clk);
    chk("req", 32'h0000_0000, 32'(irq_req[0]));
    wr(8'h80, 32'hffff_ffff);
    chk("bresp", 32'(irq_enable_pkg::RESP_SLVERR), 32'(resp));
    rd(8'h80);
    chk("rresp", 32'(irq_enable_pkg::RESP_SLVERR), 32'(resp));
    chk("rdata", 32'h0000_0000, rd_val);
    report_and_stop();
  end
endmodule
`default_nettype wire
